// ===== rtl/bjcx_exec.sv
// Purpose: executes bit-test jump, bit xor, call, pop, carry flip, clear, invert
// Assumes: register file, program and data memory reads are combinational
// Notes:   I_SP, I_RP and I_FLAGS hold still while o_BUSY is high
//          a start while busy is dropped without any indication
//          an unknown opcode pulses O_BAD_OP and changes nothing else
`timescale 1ns/1ps
`include "bjcx_regs.svh"

module bjcx_exec (
  input  wire logic        I_MCLK,      // core clock
  input  wire logic        I_RST_N,     // async reset, low
  input  wire logic        I_START,     // instruction ready pulse
  input  wire logic [7:0]  I_OPCODE,    // first byte
  input  wire logic [7:0]  I_BYTE2,     // second byte
  input  wire logic [7:0]  I_BYTE3,     // third byte
  input  wire logic [15:0] I_PC,        // address of the opcode
  input  wire logic [7:0]  I_RP,        // working register base
  input  wire logic [15:0] I_SP,        // stack pointer
  input  wire logic [7:0]  I_FLAGS,     // flags register value
  input  wire logic [7:0]  I_RF_RDATA,  // register file read data
  input  wire logic [7:0]  I_PM_RDATA,  // program memory read data
  input  wire logic [7:0]  I_DM_RDATA,  // data memory read data
  output logic      [7:0]  O_RF_RADDR,  // register read address
  output logic             O_RF_WE,     // register write strobe
  output logic      [7:0]  O_RF_WADDR,  // register write address
  output logic      [7:0]  O_RF_WDATA,  // register write data
  output logic             O_FL_WE,     // flags register write
  output logic      [7:0]  O_FL_ADDR,   // flags register address
  output logic      [7:0]  O_FL_WDATA,  // flags write data
  output logic      [15:0] O_PM_ADDR,   // program memory address
  output logic      [15:0] O_DM_ADDR,   // stack memory address
  output logic             O_DM_WE,     // stack memory write
  output logic      [7:0]  O_DM_WDATA,  // stack memory write data
  output logic             O_PC_WE,     // PC load pulse
  output logic      [15:0] O_PC,        // new PC
  output logic             O_SP_WE,     // SP load pulse
  output logic      [15:0] O_SP,        // new SP
  output logic             O_DONE,      // instruction finished
  output logic             O_BUSY,      // instruction in flight
  output logic             O_BAD_OP     // opcode not served here
);
  import bjcx_pkg::*;

  bjcx_state_s s_reg;
  bjcx_state_s s_next;

  function automatic logic [7:0] wreg(input logic [3:0] r, input logic [7:0] rp);
    wreg = {rp[7:4], r};
  endfunction

  // 8-bit operand with the working-register escape nibble
  function automatic logic [7:0] oreg(input logic [7:0] a, input logic [7:0] rp);
    oreg = (a[7:4] == `BJCX_WREG_HI) ? {rp[7:4], a[3:0]} : a;
  endfunction

  // {known, length, cycles}
  function automatic logic [6:0] dec(input logic [7:0] op);
    case (op)
      `BJCX_OP_BIT_JUMP:  dec = {1'b1, `BJCX_LEN_3, `BJCX_CYC_BIT_JUMP};
      `BJCX_OP_BIT_XOR:   dec = {1'b1, `BJCX_LEN_3, `BJCX_CYC_BIT_XOR};
      `BJCX_OP_CALL_ABS:  dec = {1'b1, `BJCX_LEN_3, `BJCX_CYC_CALL_ABS};
      `BJCX_OP_CALL_PAIR: dec = {1'b1, `BJCX_LEN_2, `BJCX_CYC_CALL_PAIR};
      `BJCX_OP_CALL_VEC:  dec = {1'b1, `BJCX_LEN_2, `BJCX_CYC_CALL_VEC};
      `BJCX_OP_EXIT:      dec = {1'b1, `BJCX_LEN_1, `BJCX_CYC_EXIT};
      `BJCX_OP_CFLIP:     dec = {1'b1, `BJCX_LEN_1, `BJCX_CYC_SHORT};
      `BJCX_OP_ZFILL_REG,
      `BJCX_OP_ZFILL_PTR: dec = {1'b1, `BJCX_LEN_2, `BJCX_CYC_SHORT};
      `BJCX_OP_INV_REG,
      `BJCX_OP_INV_PTR:   dec = {1'b1, `BJCX_LEN_2, `BJCX_CYC_SHORT};
      default:           dec = 7'h00;
    endcase
  endfunction

  always_comb begin
    logic [7:0]  rd;
    logic [7:0]  res;
    logic [7:0]  fl;
    logic [2:0]  bi;
    logic [6:0]  d;
    logic [15:0] nx;
    s_next = s_reg;
    res = 8'h00;
    fl = I_FLAGS;
    bi = s_reg.b2[3:1];
    d = 7'h00;
    nx = 16'h0000;
    rd = 8'h00;
    s_next.fl_addr = `BJCX_FLAGS_ADDR;
    s_next.done = 1'b0;
    s_next.bad = 1'b0;
    s_next.pc_we = 1'b0;
    s_next.sp_we = 1'b0;
    s_next.cyc = s_reg.cyc + 4'h1;
    case (s_reg.op)
      `BJCX_OP_CALL_VEC: rd = I_PM_RDATA;
      `BJCX_OP_EXIT:     rd = I_DM_RDATA;
      default:           rd = I_RF_RDATA;
    endcase
    case (s_reg.st)
      ST_IDLE: begin
        s_next.cyc = 4'h1;
        // a strobe left high would repeat the last write in the next instruction
        s_next.rf_we = 1'b0;
        s_next.fl_we = 1'b0;
        s_next.dm_we = 1'b0;
        if (I_START) begin
          d = dec(I_OPCODE);
          nx = I_PC + {14'h0000, d[5:4]};
          s_next.op = I_OPCODE;
          s_next.b2 = I_BYTE2;
          s_next.b3 = I_BYTE3;
          s_next.ncyc = d[3:0];
          s_next.nxt = nx;
          s_next.tgt = nx;
          s_next.spn = I_SP;
          s_next.spw = 1'b0;
          s_next.bad = ~d[6];
          s_next.busy = d[6];
          case (I_OPCODE)
            `BJCX_OP_BIT_JUMP, `BJCX_OP_BIT_XOR: begin
              s_next.st = ST_RDA;
              s_next.rf_raddr = wreg(I_BYTE2[7:4], I_RP);
            end
            `BJCX_OP_INV_REG, `BJCX_OP_CALL_PAIR: begin
              s_next.st = ST_RDA;
              s_next.rf_raddr = oreg(I_BYTE2, I_RP);
            end
            `BJCX_OP_ZFILL_PTR, `BJCX_OP_INV_PTR: begin
              s_next.st = ST_PTR;
              s_next.rf_raddr = oreg(I_BYTE2, I_RP);
            end
            `BJCX_OP_ZFILL_REG: begin
              s_next.st = ST_WRD;
              s_next.rf_we = 1'b1;
              s_next.rf_waddr = oreg(I_BYTE2, I_RP);
              s_next.rf_wdata = 8'h00;
            end
            `BJCX_OP_CFLIP: begin
              fl[`BJCX_FL_C] = ~I_FLAGS[`BJCX_FL_C];
              s_next.st = ST_WRD;
              s_next.fl_we = 1'b1;
              s_next.fl_wdata = fl;
            end
            `BJCX_OP_CALL_ABS: begin
              s_next.tgt = {I_BYTE2, I_BYTE3};
              s_next.st = ST_PSH1;
              s_next.dm_we = 1'b1;
              s_next.dm_addr = I_SP - 16'h0001;
              s_next.dm_wdata = nx[7:0];
              s_next.spn = I_SP - 16'h0002;
              s_next.spw = 1'b1;
            end
            `BJCX_OP_CALL_VEC: begin
              s_next.st = ST_RDA;
              s_next.pm_addr = {8'h00, I_BYTE2};
            end
            `BJCX_OP_EXIT: begin
              s_next.st = ST_RDA;
              s_next.dm_addr = I_SP;
            end
            default: s_next.st = ST_IDLE;
          endcase
        end
      end
      ST_PTR: begin
        // pointer register itself is only read, never written
        if (s_reg.op == `BJCX_OP_ZFILL_PTR) begin
          s_next.st = ST_WRD;
          s_next.rf_we = 1'b1;
          s_next.rf_waddr = I_RF_RDATA;
          s_next.rf_wdata = 8'h00;
        end else begin
          s_next.st = ST_RDA;
          s_next.rf_raddr = I_RF_RDATA;
        end
      end
      ST_RDA: begin
        s_next.hi = rd;
        case (s_reg.op)
          `BJCX_OP_BIT_JUMP: begin
            s_next.st = ST_WAIT;
            if (rd[bi] == s_reg.b2[0])
              s_next.tgt = s_reg.nxt + {{8{s_reg.b3[7]}}, s_reg.b3};
          end
          `BJCX_OP_INV_REG, `BJCX_OP_INV_PTR: begin
            res = ~rd;
            fl[`BJCX_FL_Z] = (res == 8'h00);
            fl[`BJCX_FL_S] = res[7];
            fl[`BJCX_FL_V] = 1'b0;
            s_next.st = ST_WRD;
            s_next.rf_we = 1'b1;
            s_next.rf_waddr = s_reg.rf_raddr;
            s_next.rf_wdata = res;
            s_next.fl_we = 1'b1;
            s_next.fl_wdata = fl;
          end
          `BJCX_OP_BIT_XOR: begin
            s_next.st = ST_RDB;
            s_next.rf_raddr = oreg(s_reg.b3, I_RP);
          end
          `BJCX_OP_CALL_PAIR: begin
            s_next.st = ST_RDB;
            s_next.rf_raddr = s_reg.rf_raddr + 8'h01;
          end
          `BJCX_OP_CALL_VEC: begin
            s_next.st = ST_RDB;
            s_next.pm_addr = s_reg.pm_addr + 16'h0001;
          end
          `BJCX_OP_EXIT: begin
            s_next.st = ST_RDB;
            s_next.dm_addr = s_reg.dm_addr + 16'h0001;
          end
          default: s_next.st = ST_WAIT;
        endcase
      end
      ST_RDB: begin
        case (s_reg.op)
          `BJCX_OP_BIT_XOR: begin
            if (!s_reg.b2[0]) begin
              res = s_reg.hi;
              res[0] = s_reg.hi[0] ^ rd[bi];
              fl[`BJCX_FL_Z] = ~res[0];
              s_next.rf_waddr = wreg(s_reg.b2[7:4], I_RP);
            end else begin
              res = rd;
              res[bi] = rd[bi] ^ s_reg.hi[0];
              fl[`BJCX_FL_Z] = ~res[bi];
              s_next.rf_waddr = oreg(s_reg.b3, I_RP);
            end
            // V is left as it was rather than made random
            fl[`BJCX_FL_S] = 1'b0;
            s_next.st = ST_WRD;
            s_next.rf_we = 1'b1;
            s_next.rf_wdata = res;
            s_next.fl_we = 1'b1;
            s_next.fl_wdata = fl;
          end
          `BJCX_OP_EXIT: begin
            s_next.tgt = {s_reg.hi, rd};
            s_next.spn = I_SP + 16'h0002;
            s_next.spw = 1'b1;
            s_next.st = ST_WAIT;
          end
          default: begin
            s_next.tgt = {s_reg.hi, rd};
            s_next.st = ST_PSH1;
            s_next.dm_we = 1'b1;
            s_next.dm_addr = I_SP - 16'h0001;
            s_next.dm_wdata = s_reg.nxt[7:0];
            s_next.spn = I_SP - 16'h0002;
            s_next.spw = 1'b1;
          end
        endcase
      end
      ST_WRD: begin
        s_next.rf_we = 1'b0;
        s_next.fl_we = 1'b0;
        s_next.st = ST_WAIT;
      end
      ST_PSH1: begin
        s_next.dm_addr = s_reg.spn;
        s_next.dm_wdata = s_reg.nxt[15:8];
        s_next.st = ST_PSH2;
      end
      ST_PSH2: begin
        s_next.dm_we = 1'b0;
        s_next.st = ST_WAIT;
      end
      ST_WAIT: begin
        // pads short paths out to the documented cycle count
        s_next.st = ST_WAIT;
      end
      default: begin
        // a corrupted state drops back to idle with every strobe off
        s_next.st = ST_IDLE;
        s_next.busy = 1'b0;
        s_next.rf_we = 1'b0;
        s_next.fl_we = 1'b0;
        s_next.dm_we = 1'b0;
      end
    endcase
    // finish on the documented cycle count whatever the path length
    if (s_next.st == ST_WAIT && s_reg.cyc >= s_reg.ncyc - 4'h1) begin
      s_next.st = ST_IDLE;
      s_next.done = 1'b1;
      s_next.busy = 1'b0;
      s_next.pc_we = 1'b1;
      s_next.pc = s_next.tgt;
      s_next.sp_we = s_next.spw;
      s_next.sp = s_next.spn;
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      s_reg.fl_addr <= `BJCX_FLAGS_ADDR;
    end else begin
      s_reg <= s_next;
    end
  end

  assign O_RF_RADDR = s_reg.rf_raddr;
  assign O_RF_WE    = s_reg.rf_we;
  assign O_RF_WADDR = s_reg.rf_waddr;
  assign O_RF_WDATA = s_reg.rf_wdata;
  assign O_FL_WE    = s_reg.fl_we;
  assign O_FL_ADDR  = s_reg.fl_addr;
  assign O_FL_WDATA = s_reg.fl_wdata;
  assign O_PM_ADDR  = s_reg.pm_addr;
  assign O_DM_ADDR  = s_reg.dm_addr;
  assign O_DM_WE    = s_reg.dm_we;
  assign O_DM_WDATA = s_reg.dm_wdata;
  assign O_PC_WE    = s_reg.pc_we;
  assign O_PC       = s_reg.pc;
  assign O_SP_WE    = s_reg.sp_we;
  assign O_SP       = s_reg.sp;
  assign O_DONE     = s_reg.done;
  assign O_BUSY     = s_reg.busy;
  assign O_BAD_OP   = s_reg.bad;
endmodule

// ===== rtl/bjcx_pkg.sv
// Purpose: types of the exec unit
// Assumes: nothing
// Notes:   the whole unit state is one packed struct
package bjcx_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_PTR, ST_RDA, ST_RDB, ST_WRD, ST_PSH1, ST_PSH2, ST_WAIT
  } bjcx_state_e;

  typedef struct packed {
    bjcx_state_e st;
    logic [7:0]  op;
    logic [7:0]  b2;
    logic [7:0]  b3;
    logic [3:0]  cyc;
    logic [3:0]  ncyc;
    logic [7:0]  hi;
    logic [15:0] nxt;
    logic [15:0] tgt;
    logic [15:0] spn;
    logic        spw;
    logic [7:0]  rf_raddr;
    logic        rf_we;
    logic [7:0]  rf_waddr;
    logic [7:0]  rf_wdata;
    logic        fl_we;
    logic [7:0]  fl_addr;
    logic [7:0]  fl_wdata;
    logic [15:0] pm_addr;
    logic [15:0] dm_addr;
    logic        dm_we;
    logic [7:0]  dm_wdata;
    logic        pc_we;
    logic [15:0] pc;
    logic        sp_we;
    logic [15:0] sp;
    logic        done;
    logic        busy;
    logic        bad;
  } bjcx_state_s;
endpackage

// ===== rtl/bjcx_regs.svh
// Purpose: opcodes, lengths, cycle counts and flag layout of the exec unit
// Assumes: included by bjcx_exec only
// Notes:   pop opcode, its cycle count and flag bit positions are local picks
`ifndef BJCX_REGS_SVH
`define BJCX_REGS_SVH
`define BJCX_OP_BIT_JUMP  8'h37
`define BJCX_OP_BIT_XOR   8'h27
`define BJCX_OP_CALL_ABS  8'hf6
`define BJCX_OP_CALL_PAIR 8'hf4
`define BJCX_OP_CALL_VEC  8'hd4
`define BJCX_OP_EXIT      8'haf
`define BJCX_OP_CFLIP     8'hef
`define BJCX_OP_ZFILL_REG 8'hb0
`define BJCX_OP_ZFILL_PTR 8'hb1
`define BJCX_OP_INV_REG   8'h60
`define BJCX_OP_INV_PTR   8'h61
`define BJCX_LEN_1       2'h1
`define BJCX_LEN_2       2'h2
`define BJCX_LEN_3       2'h3
`define BJCX_CYC_BIT_JUMP  4'ha
`define BJCX_CYC_BIT_XOR   4'h6
`define BJCX_CYC_CALL_ABS  4'he
`define BJCX_CYC_CALL_PAIR 4'hc
`define BJCX_CYC_CALL_VEC  4'he
`define BJCX_CYC_EXIT      4'he
`define BJCX_CYC_SHORT   4'h4
`define BJCX_FLAGS_ADDR  8'hd5
`define BJCX_FL_C        7
`define BJCX_FL_Z        6
`define BJCX_FL_S        5
`define BJCX_FL_V        4
`define BJCX_WREG_HI     4'hc
`endif

// ===== verification/bjcx_exec_props.sv
// Purpose: port-level timing, stack and flag checks of the exec unit
// Assumes: I_PC, I_SP and I_FLAGS held by the core while the unit is busy
// Notes:   cycle counts are tied to the accepting edge, not to o_BUSY
`timescale 1ns/1ps
module bjcx_exec_chk (
  input wire logic        I_MCLK,
  input wire logic        I_RST_N,
  input wire logic        I_START,
  input wire logic [7:0]  I_OPCODE,
  input wire logic [15:0] I_PC,
  input wire logic [15:0] I_SP,
  input wire logic [7:0]  I_FLAGS,
  input wire logic        O_FL_WE,
  input wire logic [7:0]  O_FL_ADDR,
  input wire logic [7:0]  O_FL_WDATA,
  input wire logic [15:0] O_DM_ADDR,
  input wire logic        O_DM_WE,
  input wire logic [7:0]  O_DM_WDATA,
  input wire logic [15:0] O_PC,
  input wire logic        O_SP_WE,
  input wire logic [15:0] O_SP,
  input wire logic        O_DONE,
  input wire logic        O_BUSY
);
  logic        go;
  logic [15:0] pc3;
  // a start is only taken while idle, so busy gates every antecedent
  assign go  = I_START && !O_BUSY;
  assign pc3 = I_PC + 16'h3;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  chk_flip_cycles: assert property (
    go && I_OPCODE == 8'hef |=> !O_DONE [*3] ##1 O_DONE) else $error("flip length wrong");
  chk_flip_flag: assert property (
    go && I_OPCODE == 8'hef |=> O_FL_WE && O_FL_ADDR == 8'hd5
      && O_FL_WDATA == (I_FLAGS ^ 8'h80)) else $error("flip flag write wrong");
  chk_test_cycles: assert property (
    go && I_OPCODE == 8'h37 |=> !O_DONE [*8] ##1 !O_DONE ##1 O_DONE)
    else $error("bit test length wrong");
  chk_xor_cycles: assert property (
    go && I_OPCODE == 8'h27 |-> ##6 (O_DONE && !O_BUSY)) else $error("bit xor length wrong");
  chk_call_push: assert property (
    go && I_OPCODE == 8'hf6 |=> O_DM_WE && O_DM_ADDR == I_SP - 16'h1
      && O_DM_WDATA == $past(pc3[7:0]) ##1 O_DM_WE && O_DM_ADDR == I_SP - 16'h2
      && O_DM_WDATA == $past(pc3[15:8], 2)) else $error("call push wrong");
  chk_call_sp: assert property (
    go && I_OPCODE == 8'hf6 |-> ##14 O_DONE && O_SP_WE && O_SP == I_SP - 16'h2)
    else $error("call end wrong");
  chk_short_pc: assert property (
    go && I_OPCODE inside {8'hb0, 8'hb1, 8'h60, 8'h61}
      |-> ##4 O_DONE && O_PC == $past(I_PC, 4) + 16'h2) else $error("short op end wrong");
  chk_no_flag_wr: assert property (
    go && I_OPCODE inside {8'h37, 8'hb0, 8'hb1, 8'hf6, 8'hf4, 8'hd4}
      |=> !O_FL_WE [*4]) else $error("unexpected flag write");
endmodule

bind bjcx_exec bjcx_exec_chk i_chk (.I_MCLK, .I_RST_N, .I_START, .I_OPCODE, .I_PC, .I_SP,
  .I_FLAGS, .O_FL_WE, .O_FL_ADDR, .O_FL_WDATA, .O_DM_ADDR, .O_DM_WE, .O_DM_WDATA, .O_PC,
  .O_SP_WE, .O_SP, .O_DONE, .O_BUSY);

// ===== verification/bjcx_exec_tb.sv
// Purpose: self-checking bench of the exec unit
// Assumes: register file, program and stack memory are modelled here
// Notes:   flag writes are held aside in flp so I_FLAGS stays still while busy
`timescale 1ns/1ps
module bjcx_exec_tb;
  import bjcx_pkg::*;
  logic        clk, rst_n, st, rwe, fwe, dwe, pwe, swe, done, busy, bad, r;
  logic [7:0]  op, b2, b3, irp, ifl, rp, fl, flp, x, y, v, p, d, s, e, w;
  logic [7:0]  rra, rwa, rwd, fa, fwd, dwd;
  logic [7:0]  rf [256], pm [256], dm [256];
  logic [7:0]  ops [4] = '{8'hb0, 8'hb1, 8'h60, 8'h61};
  logic [15:0] seed = 16'hb97c, pc, sp, ipc, isp, t, e16, nfw, n0, pma, dma, npc, nsp;
  int          num_errors, compares;

  bjcx_exec i_bjcx_exec (.I_MCLK(clk), .I_RST_N(rst_n), .I_START(st), .I_OPCODE(op),
    .I_BYTE2(b2), .I_BYTE3(b3), .I_PC(ipc), .I_RP(irp), .I_SP(isp), .I_FLAGS(ifl),
    .I_RF_RDATA(rf[rra]), .I_PM_RDATA(pm[pma[7:0]]), .I_DM_RDATA(dm[dma[7:0]]),
    .O_RF_RADDR(rra), .O_RF_WE(rwe), .O_RF_WADDR(rwa), .O_RF_WDATA(rwd), .O_FL_WE(fwe),
    .O_FL_ADDR(fa), .O_FL_WDATA(fwd), .O_PM_ADDR(pma), .O_DM_ADDR(dma), .O_DM_WE(dwe),
    .O_DM_WDATA(dwd), .O_PC_WE(pwe), .O_PC(npc), .O_SP_WE(swe), .O_SP(nsp),
    .O_DONE(done), .O_BUSY(busy), .O_BAD_OP(bad));

  always @(posedge clk) begin
    if (rwe === 1'b1)
      rf[rwa] <= rwd;
    if (dwe === 1'b1)
      dm[dma[7:0]] <= dwd;
    if (fwe === 1'b1) begin
      flp <= fwd;
      nfw <= nfw + 16'h1;
    end
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[7:0];
  endfunction

  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic cmp(string n, logic [15:0] ex, logic [15:0] g);
    compares++;
    if (g !== ex) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, ex, g);
    end
  endtask

  // one instruction: start sampled at the second edge, cycles counted to done
  task automatic run(logic [7:0] o, logic [7:0] a, logic [7:0] c, int n);
    int k;
    logic sw;
    @(posedge clk);
    op <= o;
    b2 <= a;
    b3 <= c;
    ipc <= pc;
    isp <= sp;
    irp <= rp;
    ifl <= fl;
    st <= 1'b1;
    @(posedge clk);
    st <= 1'b0;
    k = 0;
    do begin
      @(negedge clk);
      k++;
    end while (done !== 1'b1 && bad !== 1'b1 && k < 20);
    cmp("cycles", 16'(n), 16'(k));
    sw = o inside {8'hf6, 8'hf4, 8'hd4, 8'haf};
    cmp("pc load", {15'h0, n > 1}, {15'h0, pwe});
    cmp("sp load", {15'h0, sw}, {15'h0, swe});
    cmp("busy end", 16'h0, {15'h0, busy});
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    {rst_n, st, op, b2, b3, ipc, isp, irp, ifl, flp, nfw} = '0;
    for (int i = 0; i < 256; i++) begin
      rf[i] = rnd();
      pm[i] = rnd();
      dm[i] = rnd();
    end
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 12; i++) begin
      v = rnd();
      rp = {2'b00, v[5:0]};
      fl = rnd();
      pc = {rnd(), rnd()};
      sp = {8'h00, rnd()};
      // extreme displacements first, with the tested bit forced so the jump is taken
      x = rnd() | 8'h01;
      y = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : rnd();
      if (i < 2)
        rf[{rp[7:4], x[7:4]}][x[3:1]] = 1'b1;
      v = rf[{rp[7:4], x[7:4]}];
      t = pc + 16'h3 + (v[x[3:1]] ? {{8{y[7]}}, y} : 16'h0);
      run(8'h37, x, y, 10);
      cmp("jump pc", t, npc);
      // bank of y never equals the working bank, so source and destination differ
      v = rnd();
      x = {v[7:1], i[0]};
      y = {rp[7:4] ^ 4'h8, v[3:0]};
      w = {rp[7:4], x[7:4]};
      d = i[0] ? y : w;
      s = i[0] ? w : y;
      e = rf[d];
      p = rf[s];
      if (i[0])
        e[x[3:1]] = e[x[3:1]] ^ p[0];
      else
        e[0] = e[0] ^ p[x[3:1]];
      r = i[0] ? e[x[3:1]] : e[0];
      run(8'h27, x, y, 6);
      cmp("xor dst", e, rf[d]);
      cmp("xor src", p, rf[s]);
      cmp("xor flags", {fl[7], ~r, 1'b0, fl[4:0]}, flp);
      for (int j = 0; j < 3; j++) begin
        x = rnd();
        y = rnd();
        case (j)
          0: t = {x, y};
          1: begin
            x = {4'hc, x[3:1], 1'b0};
            t = {rf[{rp[7:4], x[3:0]}], rf[{rp[7:4], x[3:0] | 4'h1}]};
          end
          default: t = {pm[x], pm[x + 8'h1]};
        endcase
        e16 = pc + ((j == 0) ? 16'h3 : 16'h2);
        run((j == 0) ? 8'hf6 : (j == 1) ? 8'hf4 : 8'hd4, x, y, (j == 1) ? 12 : 14);
        cmp("call pc", t, npc);
        cmp("call sp", sp - 16'h2, nsp);
        cmp("ret low", e16[7:0], dm[sp[7:0] - 8'h1]);
        cmp("ret high", e16[15:8], dm[sp[7:0] - 8'h2]);
        sp = sp - 16'h2;
        run(8'haf, 8'h00, 8'h00, 14);
        cmp("exit pc", e16, npc);
        cmp("exit sp", sp + 16'h2, nsp);
      end
      run(8'hef, 8'h00, 8'h00, 4);
      cmp("flip flags", fl ^ 8'h80, flp);
      cmp("flip pc", pc + 16'h1, npc);
      foreach (ops[k]) begin
        v = rnd();
        x = {rp[7:4] ^ 4'h8, v[3:0]};
        rf[x] = {x[7:1], ~x[0]};
        d = ops[k][0] ? rf[x] : x;
        e = ops[k][7] ? 8'h00 : ~rf[d];
        n0 = nfw;
        run(ops[k], x, 8'h00, 4);
        cmp("dst", e, rf[d]);
        cmp("short pc", pc + 16'h2, npc);
        if (ops[k][0])
          cmp("pointer", {x[7:1], ~x[0]}, rf[x]);
        if (ops[k][7])
          cmp("no flags", n0, nfw);
        else
          cmp("inv flags", {fl[7], e == 8'h00, e[7], 1'b0, fl[3:0]}, flp);
      end
    end
    run(8'h00, 8'h00, 8'h00, 1);
    cmp("bad op", 16'h1, {15'h0, bad});
    report_and_stop();
  end
endmodule
